/* File: sms_map.svh */
// Purpose: offsets, field positions, codes and timing of message checking
// Assumes: included by bare name; definitions only
// Notes: alert codes are three bytes, type then subtype then information
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH

// ****************************************************************
// message layout
// ****************************************************************
`define SMS_MAX_LEN 6'd32
`define SMS_CODE_BYTE 0
`define SMS_TAG_HI_BYTE 2
`define SMS_TAG_LO_BYTE 3
`define SMS_DEF_MIN_LEN 6'd8
`define SMS_CP_PATH_BYTE 4
`define SMS_EXTEND_BIT 7
`define SMS_MA_ALERT_BYTE 16

// ****************************************************************
// message codes
// ****************************************************************
`define SMS_ULP_BASE 8'h80
`define SMS_QUERY_NODE 8'h00
`define SMS_QUERY_NODE_REPLY 8'h01
`define SMS_CONFIGURE_PORT 8'h02
`define SMS_RESPONSE 8'h03
`define SMS_ASYNC_ALERT 8'h04
`define SMS_MASTER_ALERT 8'h05
`define SMS_QUIESCE 8'h06
`define SMS_ASYNC_REPLY 8'h07
`define SMS_QUERY_PROTOCOL 8'h08
`define SMS_QUERY_PORT 8'h0a
`define SMS_REQ_SAT_REGION 8'h0e
`define SMS_LAST_PRIV 8'h11
`define SMS_RSV_PRIV_LO 8'h12
`define SMS_RSV_PRIV_HI 8'h1f
`define SMS_DATA_LO 8'h20
`define SMS_DATA_HI 8'h23
`define SMS_RSV_APP_LO 8'h24
`define SMS_RSV_APP_HI 8'h7f
`define SMS_ASYNC_ALERT_RSV_BYTE 7

// ****************************************************************
// alert codes and timing
// ****************************************************************
`define ALERT_UNKNOWN_SMS 24'h020100
`define ALERT_TOO_SHORT 24'h020300
`define ALERT_UNSUPPORTED_ULP 24'h020400
`define ALERT_BOTH_PORTS_NORMAL 24'h050300
`define ALERT_RETRY_MS 500
`define CLOCK_KHZ 100000
`endif

/* File: sms_pkg.sv */
// Purpose: types shared by the message checking files
// Assumes: nothing
// Notes: none
package sms_pkg;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic [7:0] type_b;
        logic [7:0] subtype;
        logic [7:0] info;
    } alert_code_t;

    typedef struct packed {
        logic valid;
        alert_code_t code;
    } alert_req_t;

    typedef struct packed {
        logic is_ulp;
        logic reserved;
        logic want_priv;
        logic cfg_only;
        logic master_only;
        logic overlap_class;
        logic tag_checked;
        logic data_xfer;
        logic [5:0] min_len;
        logic [31:0] rsv_mask;
    } code_class_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_CODE,
        ST_LEN,
        ST_FIELD,
        ST_TAG
    } state_t;
endpackage

/* File: sms_code_class.sv */
// Purpose: classify a message code against the supported code table
// Assumes: code is byte 0 of the received message
// Notes: purely combinational
`timescale 1ns/1ps
`include "sms_map.svh"
module sms_code_class (
    input wire logic [7:0] i_code,
    output sms_pkg::code_class_t o_class
);
    always_comb begin
        o_class = '0;
        o_class.is_ulp = (i_code >= `SMS_ULP_BASE);
        o_class.reserved = ((i_code >= `SMS_RSV_PRIV_LO) &&
            (i_code <= `SMS_RSV_PRIV_HI)) || ((i_code >= `SMS_RSV_APP_LO) &&
            (i_code <= `SMS_RSV_APP_HI));
        o_class.want_priv = (i_code <= `SMS_LAST_PRIV);
        o_class.data_xfer = (i_code >= `SMS_DATA_LO) &&
            (i_code <= `SMS_DATA_HI);
        o_class.min_len = `SMS_DEF_MIN_LEN;
        case (i_code)
            `SMS_QUERY_NODE_REPLY, `SMS_RESPONSE, 8'h09, 8'h0b,
            8'h0f: begin
                o_class.cfg_only = 1'b1;
                o_class.tag_checked = 1'b1;
            end
            `SMS_MASTER_ALERT: begin
                o_class.cfg_only = 1'b1;
                o_class.overlap_class = 1'b1;
            end
            `SMS_ASYNC_ALERT: begin
                o_class.master_only = 1'b1;
                o_class.rsv_mask[`SMS_ASYNC_ALERT_RSV_BYTE] = 1'b1;
            end
            `SMS_REQ_SAT_REGION: begin
                o_class.master_only = 1'b1;
            end
            `SMS_CONFIGURE_PORT, `SMS_QUIESCE, `SMS_QUERY_PROTOCOL,
            `SMS_QUERY_PORT: begin
                o_class.overlap_class = 1'b1;
            end
            8'h0d: begin
                o_class.tag_checked = 1'b1;
            end
            default: begin
                o_class.tag_checked = o_class.data_xfer;
            end
        endcase
    end
endmodule

/* File: sms_alert_timer.sv */
// Purpose: retransmit timing for a sent alert awaiting its reply
// Assumes: start and stop are single-cycle pulses
// Notes: start wins over stop in the same cycle
`timescale 1ns/1ps
module sms_alert_timer #(
    parameter int unsigned CYCLES = 50000000
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_stop,
    output logic o_pending,
    output logic o_expire
);
    logic [31:0] count_r;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_pending <= 1'b0;
        end else if (i_start) begin
            o_pending <= 1'b1;
        end else if (i_stop) begin
            o_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset || i_start || !o_pending) begin
            count_r <= 32'h0;
            o_expire <= 1'b0;
        end else if (count_r == CYCLES - 1) begin
            count_r <= 32'h0;
            o_expire <= !i_stop;
        end else begin
            count_r <= count_r + 32'h1;
            o_expire <= 1'b0;
        end
    end
endmodule

/* File: sms_decode_validate.sv */
// Purpose: receive-side checking of message structures in a network node
// Assumes: one message per frame, bytes arrive in order, last flagged
// Notes: checks run one stage per cycle: code, length, fields, tag
`timescale 1ns/1ps
`include "sms_map.svh"

module sms_decode_validate #(
    parameter int unsigned RETRY_CYCLES = `ALERT_RETRY_MS * `CLOCK_KHZ
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire sms_pkg::rx_byte_t i_rx,
    input wire logic i_frame_priv,
    input wire logic i_is_master,
    input wire logic i_is_configutor,
    input wire logic i_ulp_supported,
    input wire logic i_query_resources,
    input wire logic i_done,
    input wire logic [7:0] i_done_code,
    input wire logic i_tag_valid,
    input wire logic i_tag_resp_ok,
    input wire logic i_path_normal,
    input wire logic i_node_reset,
    output logic o_ulp_fwd,
    output logic o_accept,
    output logic [7:0] o_msg_code,
    output logic [15:0] o_msg_tag,
    output sms_pkg::alert_req_t o_alert,
    output logic o_alert_retx,
    output logic o_alert_pending,
    output logic [15:0] o_alert_tag,
    output logic o_alert_tag_active,
    output logic [31:0] o_alert_path,
    output logic o_overlap_resp,
    output logic o_invalid_field,
    output logic o_dropped,
    output logic [15:0] o_check_tag,
    output logic o_tag_error,
    output logic o_ulp_tag_alert,
    output logic o_node_ready
);
    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic [4:0] overlap_bit(input logic [7:0] code);
        overlap_bit = 5'h0;
        case (code)
            `SMS_CONFIGURE_PORT: overlap_bit = 5'h01;
            `SMS_MASTER_ALERT: overlap_bit = 5'h02;
            `SMS_QUERY_PORT: overlap_bit = 5'h04;
            `SMS_QUERY_PROTOCOL: overlap_bit = 5'h08;
            `SMS_QUIESCE: overlap_bit = 5'h10;
            default: overlap_bit = 5'h0;
        endcase
    endfunction

    function automatic logic [31:0] path_trim(input logic [31:0] p);
        logic keep;
        path_trim = 32'h0;
        keep = 1'b1;
        for (int i = 3; i >= 0; i--) begin
            if (keep) begin
                path_trim[i*8 +: 8] = p[i*8 +: 8];
            end
            if (!p[i*8 + `SMS_EXTEND_BIT]) begin
                keep = 1'b0;
            end
        end
    endfunction

    // ****************************************************************
    // receive buffer
    // ****************************************************************
    sms_pkg::state_t state_r;
    logic [7:0] buf_r [0:31];
    logic [5:0] count_r;
    logic priv_r;
    sms_pkg::code_class_t cls;
    logic [7:0] code;
    logic [15:0] tag;
    logic [31:0] rsv_bad;
    logic [4:0] outstanding_r;
    logic [4:0] ov_bit;
    logic node_ok;
    logic field_bad;
    logic accept;
    logic alert_fire;
    sms_pkg::alert_code_t alert_nxt;
    logic reply_match;
    logic both_normal;
    logic ready_pend_r;
    logic timer_pending;
    logic timer_expire;

    assign code = buf_r[`SMS_CODE_BYTE];
    assign tag = {buf_r[`SMS_TAG_HI_BYTE], buf_r[`SMS_TAG_LO_BYTE]};
    assign ov_bit = overlap_bit(code);

    sms_code_class u_class (
        .i_code(code),
        .o_class(cls)
    );

    always_ff @(posedge i_clock) begin
        if (i_rx.valid && state_r == sms_pkg::ST_IDLE) begin
            buf_r[0] <= i_rx.data;
        end else if (i_rx.valid && count_r < `SMS_MAX_LEN &&
            state_r == sms_pkg::ST_RECV) begin
            buf_r[count_r[4:0]] <= i_rx.data;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            count_r <= 6'h0;
            priv_r <= 1'b0;
        end else if (state_r == sms_pkg::ST_IDLE && i_rx.valid) begin
            count_r <= 6'h1;
            priv_r <= i_frame_priv;
        end else if (state_r == sms_pkg::ST_RECV && i_rx.valid &&
            count_r < `SMS_MAX_LEN) begin
            count_r <= count_r + 6'h1;
        end
    end

    // ****************************************************************
    // checking stages
    // ****************************************************************
    // pads lie beyond min_len, so their contents never reach the check
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_rsv
            assign rsv_bad[g] = cls.rsv_mask[g] && (g < cls.min_len) &&
                (buf_r[g] != 8'h00);
        end
    endgenerate

    assign node_ok = !((cls.cfg_only && !i_is_configutor) ||
        (cls.master_only && !i_is_master)) &&
        (cls.want_priv == priv_r);

    // exempt query node and its reply
    assign field_bad = (|rsv_bad) && code != `SMS_QUERY_NODE &&
        code != `SMS_QUERY_NODE_REPLY;

    assign accept = (state_r == sms_pkg::ST_FIELD && !field_bad &&
        !(cls.tag_checked && i_is_configutor)) ||
        (state_r == sms_pkg::ST_TAG && i_tag_valid && i_tag_resp_ok);

    always_comb begin
        alert_fire = 1'b0;
        alert_nxt = '0;
        if (state_r == sms_pkg::ST_CODE) begin
            if (cls.is_ulp) begin
                alert_fire = !i_ulp_supported;
                alert_nxt = `ALERT_UNSUPPORTED_ULP;
            end else if (cls.reserved || !node_ok) begin
                alert_fire = 1'b1;
                alert_nxt = `ALERT_UNKNOWN_SMS;
            end
        end else if (state_r == sms_pkg::ST_LEN &&
            count_r < cls.min_len) begin
            alert_fire = 1'b1;
            alert_nxt = `ALERT_TOO_SHORT;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_r <= sms_pkg::ST_IDLE;
        end else begin
            case (state_r)
                sms_pkg::ST_IDLE: begin
                    if (i_rx.valid) begin
                        state_r <= i_rx.last ? sms_pkg::ST_CODE :
                            sms_pkg::ST_RECV;
                    end
                end
                sms_pkg::ST_RECV: begin
                    if (i_rx.valid && i_rx.last) begin
                        state_r <= sms_pkg::ST_CODE;
                    end
                end
                sms_pkg::ST_CODE: begin
                    if (cls.is_ulp || cls.reserved || !node_ok) begin
                        state_r <= sms_pkg::ST_IDLE;
                    end else if ((|(ov_bit & outstanding_r)) ||
                        (code == `SMS_QUERY_NODE && !i_query_resources)) begin
                        state_r <= sms_pkg::ST_IDLE;
                    end else begin
                        state_r <= sms_pkg::ST_LEN;
                    end
                end
                sms_pkg::ST_LEN: begin
                    state_r <= alert_fire ? sms_pkg::ST_IDLE :
                        sms_pkg::ST_FIELD;
                end
                sms_pkg::ST_FIELD: begin
                    if (!field_bad && cls.tag_checked && i_is_configutor) begin
                        state_r <= sms_pkg::ST_TAG;
                    end else begin
                        state_r <= sms_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= sms_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // per-message result pulses
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_alert <= '0;
        end else begin
            o_alert.valid <= alert_fire;
            o_alert.code <= alert_fire ? alert_nxt : o_alert.code;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_ulp_fwd <= 1'b0;
            o_overlap_resp <= 1'b0;
            o_dropped <= 1'b0;
            o_invalid_field <= 1'b0;
        end else begin
            o_ulp_fwd <= state_r == sms_pkg::ST_CODE && cls.is_ulp &&
                i_ulp_supported;
            o_overlap_resp <= state_r == sms_pkg::ST_CODE && !cls.is_ulp &&
                !cls.reserved && node_ok && (|(ov_bit & outstanding_r));
            o_dropped <= state_r == sms_pkg::ST_CODE && node_ok &&
                code == `SMS_QUERY_NODE && !i_query_resources;
            o_invalid_field <= state_r == sms_pkg::ST_FIELD && field_bad;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_accept <= 1'b0;
            o_msg_code <= 8'h00;
            o_msg_tag <= 16'h0000;
            o_check_tag <= 16'h0000;
        end else begin
            o_accept <= accept;
            if (state_r == sms_pkg::ST_CODE) begin
                o_msg_code <= code;
                o_msg_tag <= tag;
                o_check_tag <= tag;
            end
        end
    end

    // tag pool lookup answers two cycles after o_check_tag settles
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_tag_error <= 1'b0;
            o_ulp_tag_alert <= 1'b0;
        end else begin
            o_tag_error <= state_r == sms_pkg::ST_TAG &&
                !(i_tag_valid && i_tag_resp_ok);
            o_ulp_tag_alert <= state_r == sms_pkg::ST_TAG &&
                !(i_tag_valid && i_tag_resp_ok) && cls.data_xfer;
        end
    end

    // ****************************************************************
    // outstanding overlap-class messages
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            outstanding_r <= 5'h0;
        end else begin
            // a new arrival wins over a completion in the same cycle
            outstanding_r <= (outstanding_r &
                ~(i_done ? overlap_bit(i_done_code) : 5'h0)) |
                (accept ? ov_bit : 5'h0);
        end
    end

    // ****************************************************************
    // alert tag and return path
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_alert_tag_active <= 1'b0;
            o_alert_tag <= 16'h0000;
            o_alert_path <= 32'h0;
        end else if (accept && code == `SMS_CONFIGURE_PORT) begin
            o_alert_tag_active <= 1'b1;
            o_alert_tag <= tag;
            o_alert_path <= path_trim({buf_r[`SMS_CP_PATH_BYTE],
                buf_r[`SMS_CP_PATH_BYTE + 1], buf_r[`SMS_CP_PATH_BYTE + 2],
                buf_r[`SMS_CP_PATH_BYTE + 3]});
        end else if (i_node_reset) begin
            o_alert_tag_active <= 1'b0;
        end
    end

    // ****************************************************************
    // alert retransmission
    // ****************************************************************
    // a reply for another tag, or with nothing pending, is discarded
    assign reply_match = accept && code == `SMS_ASYNC_REPLY &&
        tag == o_alert_tag && timer_pending;

    sms_alert_timer #(
        .CYCLES(RETRY_CYCLES)
    ) u_timer (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_start(alert_fire),
        .i_stop(reply_match || i_node_reset),
        .o_pending(timer_pending),
        .o_expire(timer_expire)
    );

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_alert_retx <= 1'b0;
            o_alert_pending <= 1'b0;
        end else begin
            o_alert_retx <= timer_expire;
            o_alert_pending <= timer_pending;
        end
    end

    // ****************************************************************
    // node ready held until the path is normal
    // ****************************************************************
    assign both_normal = accept && code == `SMS_MASTER_ALERT &&
        {buf_r[`SMS_MA_ALERT_BYTE], buf_r[`SMS_MA_ALERT_BYTE + 1],
        buf_r[`SMS_MA_ALERT_BYTE + 2]} == `ALERT_BOTH_PORTS_NORMAL;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ready_pend_r <= 1'b0;
            o_node_ready <= 1'b0;
        end else begin
            ready_pend_r <= both_normal || (ready_pend_r && !i_path_normal);
            o_node_ready <= ready_pend_r && i_path_normal;
        end
    end
endmodule

/* File: sms_decode_validate_checker.sv */
// Purpose: port timing checks for the message checker
// Assumes: one message per frame, idle gap between messages
// Notes: byte index is counted here from the receive stream
`timescale 1ns/1ps
`include "sms_map.svh"
module sms_decode_validate_checker (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire sms_pkg::rx_byte_t i_rx,
    input wire logic i_frame_priv,
    input wire logic i_ulp_supported,
    input wire logic i_query_resources,
    input wire logic i_path_normal,
    input wire logic i_node_reset,
    input wire logic o_ulp_fwd,
    input wire logic o_accept,
    input wire logic [15:0] o_msg_tag,
    input wire sms_pkg::alert_req_t o_alert,
    input wire logic o_alert_pending,
    input wire logic o_alert_tag_active,
    input wire logic o_overlap_resp,
    input wire logic o_dropped,
    input wire logic o_node_ready
);
    logic [5:0] idx_r;
    logic [5:0] len_r;
    logic [7:0] code_r;
    logic [15:0] tag_r;
    logic [7:0] code_now;
    logic msg_end;
    assign msg_end = i_rx.valid && i_rx.last;
    assign code_now = (idx_r == 6'h00) ? i_rx.data : code_r;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            idx_r <= 6'h00;
        end else if (i_rx.valid) begin
            idx_r <= i_rx.last ? 6'h00 : idx_r + 6'h01;
        end
    end
    // tag bytes 2 and 3 shift in, so byte 2 lands on top
    always_ff @(posedge i_clock) begin
        if (i_rx.valid && idx_r == 6'h00) code_r <= i_rx.data;
        if (i_rx.valid && idx_r[5:1] == 5'h01) tag_r <= {tag_r[7:0], i_rx.data};
        if (msg_end) len_r <= idx_r + 6'h01;
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence ended(logic [7:0] lo, logic [7:0] hi);
        msg_end && code_now >= lo && code_now <= hi;
    endsequence
    sequence alert_is(logic [23:0] c);
        o_alert.valid && o_alert.code == c;
    endsequence
    a_ulp_forward: assert property (ended(8'h80, 8'hff) ##1 i_ulp_supported
        |-> ##1 o_ulp_fwd) else $error("ulp message not forwarded");
    a_ulp_unsupported: assert property (ended(8'h80, 8'hff) ##1 !i_ulp_supported
        |-> ##1 alert_is(`ALERT_UNSUPPORTED_ULP)) else $error("no ulp alert");
    a_rsv_priv: assert property (ended(8'h12, 8'h1f)
        |-> ##2 alert_is(`ALERT_UNKNOWN_SMS)) else $error("no alert, code");
    a_rsv_app: assert property (ended(8'h24, 8'h7f)
        |-> ##2 alert_is(`ALERT_UNKNOWN_SMS)) else $error("no alert, code");
    a_frame_priv: assert property (ended(8'h00, 8'h11) ##0 !i_frame_priv
        |-> ##2 alert_is(`ALERT_UNKNOWN_SMS)) else $error("no alert, frame");
    a_frame_app: assert property (ended(8'h20, 8'h23) ##0 i_frame_priv
        |-> ##2 alert_is(`ALERT_UNKNOWN_SMS)) else $error("no alert, frame");
    a_too_short: assert property (alert_is(`ALERT_TOO_SHORT)
        |-> len_r < `SMS_DEF_MIN_LEN) else $error("short alert, long message");
    a_short_stop: assert property (ended(8'h00, 8'h7f) ##0 idx_r < 6'h07
        |-> ##1 !o_accept [*5]) else $error("short message accepted");
    a_alert_final: assert property (o_alert.valid
        |-> ##1 (!o_accept && !o_overlap_resp) [*3]) else $error("reply after alert");
    a_drop_silent: assert property (ended(8'h00, 8'h00) ##0 i_frame_priv
        ##1 !i_query_resources |-> ##1 o_dropped ##1 (!o_accept && !o_alert.valid) [*3])
        else $error("query not dropped silently");
    a_tag_pair: assert property (o_accept |-> o_msg_tag == tag_r)
        else $error("tag bytes paired wrongly");
    a_reset_frees: assert property (i_node_reset
        |-> ##[1:2] !o_alert_tag_active && !o_alert_pending) else $error("tag kept");
    a_alert_pend: assert property (o_alert.valid |-> ##[0:1] o_alert_pending)
        else $error("alert not pending");
    a_path_wait: assert property (!i_path_normal && !$past(i_path_normal)
        |-> !o_node_ready) else $error("node ready before path normal");
endmodule

/* File: sms_peer_model.sv */
// Purpose: far-end peer sending one message per frame
// Assumes: caller builds a zero-padded message
// Notes: idle data line shows the inverse of the last byte
`timescale 1ns/1ps
module sms_peer_model (
    input wire logic i_clock,
    output sms_pkg::rx_byte_t o_rx,
    output logic o_priv
);
    logic [7:0] held_r;
    initial begin
        o_rx = '0;
        o_priv = 1'b1;
    end
    // never more than 32 bytes, code first, tag in bytes 2 and 3
    task automatic send(input logic [7:0] m[32], input int n, input logic p);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clock);
            o_priv <= p;
            o_rx <= '{1'b1, k == n - 1, m[k]};
            held_r = m[k];
        end
        @(posedge i_clock);
        o_rx <= '{1'b0, 1'b0, ~held_r};
    endtask
endmodule

/* File: sms_decode_validate_bench.sv */
// Purpose: self-checking bench for the message checker
// Assumes: retry period shortened to 20 cycles
// Notes: retransmit pulses are counted apart from the queue
`timescale 1ns/1ps
`include "sms_map.svh"
module sms_decode_validate_bench;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    sms_pkg::rx_byte_t i_rx;
    logic i_frame_priv;
    logic i_is_master = 1'b1;
    logic i_is_configutor = 1'b1;
    logic i_ulp_supported = 1'b1;
    logic i_query_resources = 1'b1;
    logic i_done = 1'b0;
    logic [7:0] i_done_code = 8'h00;
    logic i_tag_valid = 1'b1;
    logic i_tag_resp_ok = 1'b1;
    logic i_path_normal = 1'b0;
    logic i_node_reset = 1'b0;
    logic o_ulp_fwd, o_accept, o_alert_retx, o_alert_pending, o_dropped;
    logic o_alert_tag_active, o_overlap_resp, o_invalid_field, o_node_ready;
    logic o_tag_error, o_ulp_tag_alert;
    logic [7:0] o_msg_code;
    logic [15:0] o_msg_tag, o_alert_tag, o_check_tag;
    logic [31:0] o_alert_path;
    sms_pkg::alert_req_t o_alert;
    logic [31:0] exp_q[$];
    logic [7:0] m[32];
    logic [15:0] tag;
    logic [23:0] ma = 24'h0;
    logic [8:0] bad[6] = '{9'h112, 9'h11f, 9'h024, 9'h07f, 9'h002, 9'h120};
    int error_cnt = 0;
    int tests_run = 0;
    int retx_cnt = 0;
    int cyc = 0;
    sms_decode_validate #(.RETRY_CYCLES(20)) dut (.*);
    sms_peer_model peer (.i_clock(i_clock), .o_rx(i_rx), .o_priv(i_frame_priv));
    initial forever #5 i_clock = ~i_clock;
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic ex(input logic [7:0] k, input logic [23:0] v);
        exp_q.push_back({k, v});
    endtask
    // pad bytes stay zero, as a sender must
    task automatic msg(input logic [7:0] c, input int n, input logic p,
                       input logic [31:0] body);
        m = '{default: 8'h00};
        m[0] = c;
        {m[2], m[3], m[4], m[5], m[6], m[7]} = {tag, body};
        {m[16], m[17], m[18]} = ma;
        peer.send(m, n, p);
        repeat (8) @(posedge i_clock);
    endtask
    // ****************************************************************
    // result watcher: one queue note per pulse
    // ****************************************************************
    always @(posedge i_clock) begin
        logic [31:0] g;
        g = 32'h0;
        if (o_accept === 1'b1) g = {8'h01, o_msg_tag, o_msg_code};
        else if (o_alert.valid === 1'b1) g = {8'h02, o_alert.code};
        else if (o_overlap_resp === 1'b1) g = 32'h0300_0000;
        else if (o_dropped === 1'b1) g = 32'h0400_0000;
        else if (o_ulp_fwd === 1'b1) g = 32'h0500_0000;
        else if (o_tag_error === 1'b1) g = {8'h06, 23'h0, o_ulp_tag_alert};
        else if (o_invalid_field === 1'b1) g = 32'h0700_0000;
        else if (o_node_ready === 1'b1) g = 32'h0800_0000;
        if (o_alert_retx === 1'b1) retx_cnt++;
        if (g != 32'h0) cmp(exp_q.size() > 0 ? exp_q.pop_front() : 32'h0, g);
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(23));
        tag = 16'($urandom());
        repeat (20) @(posedge i_clock);
        i_reset <= 1'b0;
        ex(8'h01, {tag, 8'h02});
        msg(8'h02, 8, 1'b1, 32'h8105_aabb);
        cmp({tag, tag}, {o_alert_tag, o_check_tag});
        cmp(32'h8105_0000, o_alert_path);
        ex(8'h03, 24'h0);
        msg(8'h02, 8, 1'b1, 32'h0);
        i_done <= 1'b1;
        i_done_code <= 8'h02;
        @(posedge i_clock);
        i_done <= 1'b0;
        foreach (bad[i]) ex(8'h02, `ALERT_UNKNOWN_SMS);
        foreach (bad[i]) msg(bad[i][7:0], 8, bad[i][8], 32'h0);
        ex(8'h05, 24'h0);
        msg(8'h80 | 8'($urandom()), 8, 1'b0, 32'h0);
        i_ulp_supported <= 1'b0;
        ex(8'h02, `ALERT_UNSUPPORTED_ULP);
        msg(8'hff, 8, 1'b1, 32'h0);
        i_ulp_supported <= 1'b1;
        ex(8'h02, `ALERT_TOO_SHORT);
        msg(8'h08, 7, 1'b1, 32'h0);
        ex(8'h01, {tag, 8'h0a});
        msg(8'h0a, 32, 1'b1, 32'h0);
        i_query_resources <= 1'b0;
        ex(8'h04, 24'h0);
        msg(8'h00, 8, 1'b1, 32'h0);
        i_query_resources <= 1'b1;
        ex(8'h01, {tag, 8'h00});
        msg(8'h00, 8, 1'b1, 32'h0);
        ex(8'h07, 24'h0);
        msg(8'h04, 8, 1'b1, 32'h0201_0001);
        i_tag_valid <= 1'b0;
        ex(8'h06, 24'h0);
        msg(8'h01, 8, 1'b1, 32'h0);
        ex(8'h06, 24'h1);
        msg(8'h20, 8, 1'b0, 32'h0);
        i_tag_valid <= 1'b1;
        ma = `ALERT_BOTH_PORTS_NORMAL;
        ex(8'h01, {tag, 8'h05});
        msg(8'h05, 19, 1'b1, 32'h0);
        ex(8'h08, 24'h0);
        i_path_normal <= 1'b1;
        ex(8'h02, `ALERT_UNKNOWN_SMS);
        msg(8'h13, 8, 1'b1, 32'h0);
        retx_cnt = 0;
        repeat (40) @(posedge i_clock);
        cmp(32'd2, 32'(retx_cnt));
        ex(8'h01, {tag, 8'h07});
        msg(8'h07, 8, 1'b1, 32'h0);
        cmp(32'h0, {31'h0, o_alert_pending});
        i_node_reset <= 1'b1;
        @(posedge i_clock);
        i_node_reset <= 1'b0;
        repeat (3) @(posedge i_clock);
        cmp(32'h0, {31'h0, o_alert_tag_active});
        cmp(32'h0, 32'(exp_q.size()));
        end_sim();
    end
endmodule
bind sms_decode_validate sms_decode_validate_checker chk (.*);
